/* hw/dsp_cfg.svh */
// constants for the double-data-rate separate-io sram port
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ----------------------------------------
// widths and write-buffer depth
// ----------------------------------------
`define DSP_LANE_W       9
`define DSP_DATA_W       36
`define DSP_ADDR_W       8
`define DSP_BUF_N        4

// ----------------------------------------
// field positions in the sampled pin vector
// ----------------------------------------
`define DSP_POS_K        0
`define DSP_POS_KN       1
`define DSP_POS_C        2
`define DSP_POS_CN       3
`define DSP_POS_LD_N     4
`define DSP_POS_RW       5
`define DSP_POS_ADDR     6

// ----------------------------------------
// reset values
// ----------------------------------------
`define DSP_EN_N_RST     1'b1
`define DSP_ECHO_POS_RST 1'b0
`define DSP_ECHO_NEG_RST 1'b1
`define DSP_CLK_PREV_RST 4'h0

`endif

/* hw/dsp_pkg.sv */
// types shared by the sram port
package dsp_pkg;

	typedef enum logic [1:0] {
		RD_IDLE,
		RD_WAIT_POS,
		RD_WAIT_NEG,
		RD_WAIT_POS2
	} dsp_rd_state_type;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_BEAT0,
		WR_BEAT1
	} dsp_wr_state_type;

endpackage : dsp_pkg

/* hw/dsp_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps

module dsp_sync #(
	parameter int          W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else if (ce) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;

endmodule : dsp_sync

/* hw/dsp_port.sv */
// command, write-buffer and read-beat logic of the sram port
`timescale 1ns/1ps
`include "dsp_cfg.svh"

// Contract
// - second beat index is the start index plus one
// - load strobe low at input clock rise registers the address
// - load strobe high is a no-operation; outputs stay high impedance
// - load with select high starts a two-beat read
// - read beats go out on the neg rise after the next output pos rise, then the pos rise after that
// - load with select low starts a two-beat write
// - pending bursts finish before clock stop; outputs hold while stopped
// - 18-bit width: two active-low lane enables, all high aborts beat
// - 36-bit width: four active-low lane enables, all high aborts beat
// - writes buffered; reads of the last two bursts see buffer data
// - output clocks both tied high: input clocks time the read beats
// - read commands never write the array
module dsp_port #(
	parameter int LW    = `DSP_LANE_W,
	parameter int DW    = `DSP_DATA_W,
	parameter int AW    = `DSP_ADDR_W,
	parameter int BUF_N = `DSP_BUF_N
) (
	input  wire logic          CORE_CLK,
	input  wire logic          RST,
	input  wire logic          CLK_EN,
	input  wire logic          K_CLK,
	input  wire logic          K_CLK_N,
	input  wire logic          OUT_CLK,
	input  wire logic          OUT_CLK_N,
	input  wire logic          LOAD_STROBE_N,
	input  wire logic          READ_WRITE,
	input  wire logic [AW-1:0] ADDR,
	input  wire logic [DW/LW-1:0] BYTE_LANE_WRITE_N,
	input  wire logic [DW-1:0] DATA_IN,
	output logic      [DW-1:0] DATA_OUT,
	output logic               DATA_OUT_EN_N,
	output logic               ECHO_CLOCK_POS,
	output logic               ECHO_CLOCK_NEG
);

	localparam int NB = DW / LW;
	localparam int SW = `DSP_POS_ADDR + AW + NB + DW;
	localparam logic [SW-1:0] SYNC_INIT = SW'(1) << `DSP_POS_LD_N;
	localparam logic [AW:0] IDX_ONE = (AW+1)'(1);

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [SW-1:0]  s_all;
	logic           s_k;
	logic           s_kn;
	logic           s_c;
	logic           s_cn;
	logic           s_ld_n;
	logic           s_rw;
	logic [AW-1:0]  s_addr;
	logic [NB-1:0]  s_bw_n;
	logic [DW-1:0]  s_din;

	dsp_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
		.clk  (CORE_CLK),
		.rst  (RST),
		.ce   (CLK_EN),
		.din  ({DATA_IN, BYTE_LANE_WRITE_N, ADDR, READ_WRITE, LOAD_STROBE_N,
			OUT_CLK_N, OUT_CLK, K_CLK_N, K_CLK}),
		.dout (s_all)
	);

	assign s_k    = s_all[`DSP_POS_K];
	assign s_kn   = s_all[`DSP_POS_KN];
	assign s_c    = s_all[`DSP_POS_C];
	assign s_cn   = s_all[`DSP_POS_CN];
	assign s_ld_n = s_all[`DSP_POS_LD_N];
	assign s_rw   = s_all[`DSP_POS_RW];
	assign s_addr = s_all[`DSP_POS_ADDR +: AW];
	assign s_bw_n = s_all[`DSP_POS_ADDR + AW +: NB];
	assign s_din  = s_all[`DSP_POS_ADDR + AW + NB +: DW];

	// ----------------------------------------
	// edges and clock mode
	// ----------------------------------------
	logic [3:0] clk_prev_q;
	logic [3:0] clk_prev_d;
	logic       tied_q;
	logic       tied_d;
	logic       k_rise;
	logic       kn_rise;
	logic       pos_rise;
	logic       neg_rise;
	logic       cmd_load;
	logic       cmd_read;
	logic       cmd_write;

	always_comb begin
		clk_prev_d = s_all[3:0];
		// free-running output clocks are never both high for two samples
		tied_d     = s_c & s_cn & clk_prev_q[2] & clk_prev_q[3];
	end

	assign k_rise    = s_k & ~clk_prev_q[0];
	assign kn_rise   = s_kn & ~clk_prev_q[1];
	assign pos_rise  = tied_q ? k_rise : (s_c & ~clk_prev_q[2]);
	assign neg_rise  = tied_q ? kn_rise : (s_cn & ~clk_prev_q[3]);
	assign cmd_load  = k_rise & ~s_ld_n;
	assign cmd_read  = cmd_load & s_rw;
	assign cmd_write = cmd_load & ~s_rw;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			clk_prev_q <= `DSP_CLK_PREV_RST;
			tied_q     <= 1'b0;
		end else if (CLK_EN) begin
			clk_prev_q <= clk_prev_d;
			tied_q     <= tied_d;
		end
	end

	// ----------------------------------------
	// array, write buffer and lookup
	// ----------------------------------------
	logic [DW-1:0] mem [0:(2**(AW+1))-1];
	logic [AW:0]   buf_idx_q [BUF_N];
	logic [AW:0]   buf_idx_d [BUF_N];
	logic [DW-1:0] buf_dat_q [BUF_N];
	logic [DW-1:0] buf_dat_d [BUF_N];
	logic [NB-1:0] buf_msk_q [BUF_N];
	logic [NB-1:0] buf_msk_d [BUF_N];
	logic [BUF_N-1:0] buf_v_q;
	logic [BUF_N-1:0] buf_v_d;
	logic          mem_we;
	logic [AW:0]   mem_idx;
	logic [DW-1:0] mem_wdata;

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
		input logic [DW-1:0] new_w, input logic [NB-1:0] msk);
		logic [DW-1:0] r;
		r = old_w;
		for (int b = 0; b < NB; b++) begin
			if (msk[b]) begin
				r[b*LW +: LW] = new_w[b*LW +: LW];
			end
		end
		return r;
	endfunction : merge

	// oldest entry first so the newest write wins each lane
	function automatic logic [DW-1:0] lookup(input logic [AW:0] idx);
		logic [DW-1:0] w;
		w = mem[idx];
		for (int i = BUF_N - 1; i >= 0; i--) begin
			if (buf_v_q[i] && buf_idx_q[i] == idx) begin
				w = merge(w, buf_dat_q[i], buf_msk_q[i]);
			end
		end
		return w;
	endfunction : lookup

	// ----------------------------------------
	// write path
	// ----------------------------------------
	dsp_pkg::dsp_wr_state_type wr_state_q;
	dsp_pkg::dsp_wr_state_type wr_state_d;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] addr_d;
	logic          push;
	logic [AW:0]   push_idx;

	always_comb begin
		wr_state_d = wr_state_q;
		addr_d     = addr_q;
		push       = 1'b0;
		push_idx   = {addr_q, 1'b0};
		case (wr_state_q)
			dsp_pkg::WR_BEAT0: begin
				if (k_rise) begin
					push       = 1'b1;
					wr_state_d = dsp_pkg::WR_BEAT1;
				end
			end
			dsp_pkg::WR_BEAT1: begin
				if (kn_rise) begin
					push       = 1'b1;
					push_idx   = {addr_q, 1'b0} + IDX_ONE;
					wr_state_d = dsp_pkg::WR_IDLE;
				end
			end
			default: ;
		endcase
		if (cmd_load) begin
			addr_d = s_addr;
		end
		if (cmd_write) begin
			wr_state_d = dsp_pkg::WR_BEAT0;
		end
	end

	// commit happens only on a beat push, so reads never touch the array
	always_comb begin
		buf_idx_d = buf_idx_q;
		buf_dat_d = buf_dat_q;
		buf_msk_d = buf_msk_q;
		buf_v_d   = buf_v_q;
		mem_we    = push & buf_v_q[BUF_N-1];
		mem_idx   = buf_idx_q[BUF_N-1];
		mem_wdata = merge(mem[buf_idx_q[BUF_N-1]], buf_dat_q[BUF_N-1],
			buf_msk_q[BUF_N-1]);
		if (push) begin
			for (int i = BUF_N - 1; i > 0; i--) begin
				buf_idx_d[i] = buf_idx_q[i-1];
				buf_dat_d[i] = buf_dat_q[i-1];
				buf_msk_d[i] = buf_msk_q[i-1];
				buf_v_d[i]   = buf_v_q[i-1];
			end
			buf_idx_d[0] = push_idx;
			buf_dat_d[0] = s_din;
			buf_msk_d[0] = ~s_bw_n;
			buf_v_d[0]   = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			wr_state_q <= dsp_pkg::WR_IDLE;
			addr_q     <= '0;
			buf_v_q    <= '0;
			for (int i = 0; i < BUF_N; i++) begin
				buf_idx_q[i] <= '0;
				buf_dat_q[i] <= '0;
				buf_msk_q[i] <= '0;
			end
		end else if (CLK_EN) begin
			wr_state_q <= wr_state_d;
			addr_q     <= addr_d;
			buf_v_q    <= buf_v_d;
			buf_idx_q  <= buf_idx_d;
			buf_dat_q  <= buf_dat_d;
			buf_msk_q  <= buf_msk_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (CLK_EN && mem_we) begin
			mem[mem_idx] <= mem_wdata;
		end
	end

	// ----------------------------------------
	// read path and echo clocks
	// ----------------------------------------
	dsp_pkg::dsp_rd_state_type rd_state_q;
	dsp_pkg::dsp_rd_state_type rd_state_d;
	logic [DW-1:0] rd_w0_q;
	logic [DW-1:0] rd_w0_d;
	logic [DW-1:0] rd_w1_q;
	logic [DW-1:0] rd_w1_d;
	logic [DW-1:0] dout_q;
	logic [DW-1:0] dout_d;
	logic          en_n_q;
	logic          en_n_d;
	logic          echo_pos_q;
	logic          echo_pos_d;
	logic          echo_neg_q;
	logic          echo_neg_d;

	// without an edge nothing below moves, so a stopped clock holds the pins
	always_comb begin
		rd_state_d = rd_state_q;
		rd_w0_d    = rd_w0_q;
		rd_w1_d    = rd_w1_q;
		dout_d     = dout_q;
		en_n_d     = en_n_q;
		echo_pos_d = echo_pos_q;
		echo_neg_d = echo_neg_q;
		if (pos_rise) begin
			echo_pos_d = 1'b1;
			echo_neg_d = 1'b0;
		end else if (neg_rise) begin
			echo_pos_d = 1'b0;
			echo_neg_d = 1'b1;
		end
		case (rd_state_q)
			dsp_pkg::RD_IDLE: begin
				if (neg_rise) begin
					en_n_d = 1'b1;
				end
			end
			dsp_pkg::RD_WAIT_POS: begin
				if (pos_rise) begin
					rd_state_d = dsp_pkg::RD_WAIT_NEG;
				end
			end
			dsp_pkg::RD_WAIT_NEG: begin
				if (neg_rise) begin
					dout_d     = rd_w0_q;
					en_n_d     = 1'b0;
					rd_state_d = dsp_pkg::RD_WAIT_POS2;
				end
			end
			dsp_pkg::RD_WAIT_POS2: begin
				if (pos_rise) begin
					dout_d     = rd_w1_q;
					rd_state_d = dsp_pkg::RD_IDLE;
				end
			end
			default: rd_state_d = dsp_pkg::RD_IDLE;
		endcase
		if (cmd_read) begin
			rd_state_d = dsp_pkg::RD_WAIT_POS;
			rd_w0_d    = lookup({s_addr, 1'b0});
			rd_w1_d    = lookup({s_addr, 1'b0} + IDX_ONE);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rd_state_q <= dsp_pkg::RD_IDLE;
			rd_w0_q    <= '0;
			rd_w1_q    <= '0;
			dout_q     <= '0;
			en_n_q     <= `DSP_EN_N_RST;
			echo_pos_q <= `DSP_ECHO_POS_RST;
			echo_neg_q <= `DSP_ECHO_NEG_RST;
		end else if (CLK_EN) begin
			rd_state_q <= rd_state_d;
			rd_w0_q    <= rd_w0_d;
			rd_w1_q    <= rd_w1_d;
			dout_q     <= dout_d;
			en_n_q     <= en_n_d;
			echo_pos_q <= echo_pos_d;
			echo_neg_q <= echo_neg_d;
		end
	end

	assign DATA_OUT       = dout_q;
	assign DATA_OUT_EN_N  = en_n_q;
	assign ECHO_CLOCK_POS = echo_pos_q;
	assign ECHO_CLOCK_NEG = echo_neg_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST || !CLK_EN);

	sequence read_cmd_s;
		cmd_read;
	endsequence
	sequence write_cmd_s;
		cmd_write;
	endsequence
	sequence beat0_s;
		rd_state_q == dsp_pkg::RD_WAIT_NEG && neg_rise && !cmd_read;
	endsequence

	burst_index_a: assert property (read_cmd_s |=> rd_w1_q == lookup({addr_q, 1'b0} + IDX_ONE))
		else $error("second beat not from start index plus one");
	load_addr_a: assert property (cmd_load |=> addr_q == $past(s_addr))
		else $error("load did not register the address");
	nop_hiz_a: assert property (k_rise && s_ld_n && rd_state_q == dsp_pkg::RD_IDLE && en_n_q
		|=> DATA_OUT_EN_N)
		else $error("output driven after no-operation");
	read_start_a: assert property (read_cmd_s |=> rd_state_q == dsp_pkg::RD_WAIT_POS)
		else $error("read command did not start a burst");
	first_beat_a: assert property (beat0_s |=> !DATA_OUT_EN_N && DATA_OUT == $past(rd_w0_q))
		else $error("first read beat wrong");
	write_start_a: assert property (write_cmd_s |=> wr_state_q == dsp_pkg::WR_BEAT0)
		else $error("write command did not start a burst");
	stop_hold_a: assert property (!pos_rise && !neg_rise && !cmd_read
		|=> $stable(DATA_OUT) && $stable(DATA_OUT_EN_N))
		else $error("outputs moved without an output clock edge");
	lane_mask_a: assert property (push |=> buf_msk_q[0] == ~$past(s_bw_n))
		else $error("lane mask not taken from enables");
	tied_mode_a: assert property (tied_q && kn_rise |=> !ECHO_CLOCK_POS && ECHO_CLOCK_NEG)
		else $error("input clock not timing reads in tied mode");
	no_read_write_a: assert property (mem_we |-> push && !cmd_read)
		else $error("array written outside a write beat");
	echo_edge_a: assert property (pos_rise |=> ECHO_CLOCK_POS && !ECHO_CLOCK_NEG)
		else $error("echo clocks not following output edge");

endmodule : dsp_port

/* sim/dsp_master.sv */
// behavioural bus master driving the sram port pins
`timescale 1ns/1ps

module dsp_master #(
	parameter int DW = 36,
	parameter int NB = 4,
	parameter int AW = 8
) (
	input  wire logic          tied,
	output logic               k_clk,
	output logic               k_clk_n,
	output logic               out_clk,
	output logic               out_clk_n,
	output logic               load_strobe_n,
	output logic               read_write,
	output logic [AW-1:0]      addr,
	output logic [NB-1:0]      byte_lane_write_n,
	output logic [DW-1:0]      din,
	input  wire logic [DW-1:0] q,
	input  wire logic          q_en_n,
	input  wire logic          echo_pos,
	input  wire logic          echo_neg
);
	logic [DW-1:0] q_a;
	logic [DW-1:0] q_b;
	logic          en_a;
	logic          en_b;
	logic [1:0]    echo_a;
	logic [1:0]    echo_b;

	// output clocks follow the input pair unless tied high
	assign out_clk   = tied | k_clk;
	assign out_clk_n = tied | k_clk_n;

	initial begin
		k_clk = 1'b0;
		k_clk_n = 1'b1;
		load_strobe_n = 1'b1;
		read_write = 1'b1;
		addr = '0;
		byte_lane_write_n = '1;
		din = '0;
	end

	// one input clock period; clocks stand still between calls
	// don't-care pins flip so a stale value never passes for a driven one
	// samples sit 50 ns after each rise, before the answer can move on
	task automatic tick(input logic ld, input logic rw, input logic [AW-1:0] a,
			input logic [NB-1:0] m0, input logic [DW-1:0] d0,
			input logic [NB-1:0] m1, input logic [DW-1:0] d1);
		load_strobe_n = ld;
		read_write = ld ? ~read_write : rw;
		addr = ld ? ~addr : a;
		byte_lane_write_n = m0;
		din = &m0 ? ~din : d0;
		#20;
		k_clk = 1'b1;
		k_clk_n = 1'b0;
		#50;
		q_a = q;
		en_a = q_en_n;
		echo_a = {echo_pos, echo_neg};
		#30;
		byte_lane_write_n = m1;
		din = &m1 ? ~din : d1;
		#20;
		k_clk = 1'b0;
		k_clk_n = 1'b1;
		#50;
		q_b = q;
		en_b = q_en_n;
		echo_b = {echo_pos, echo_neg};
		#30;
	endtask : tick

endmodule : dsp_master

/* sim/dsp_port_bench.sv */
// self-checking bench of the sram port against a behavioural master
`timescale 1ns/1ps
`include "dsp_cfg.svh"
`define DSP_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module dsp_port_bench;
	localparam int DW = `DSP_DATA_W;
	localparam int NB = `DSP_DATA_W / `DSP_LANE_W;
	localparam int AW = `DSP_ADDR_W;
	localparam logic [DW-1:0] W0 = 36'h1_2345_6789;
	localparam logic [DW-1:0] W1 = 36'hE_DCBA_9876;
	localparam logic [DW-1:0] P1 = 36'h5_A5A5_A5A5;

	logic          core_clk;
	logic          rst;
	logic          tied;
	logic          clk_en;
	logic          k_clk;
	logic          k_clk_n;
	logic          out_clk;
	logic          out_clk_n;
	logic          ld_n;
	logic          rw;
	logic [AW-1:0] addr;
	logic [NB-1:0] lanes_n;
	logic [DW-1:0] din;
	logic [DW-1:0] dout;
	logic          dout_en_n;
	logic          echo_pos;
	logic          echo_neg;
	int            error_cnt;
	int            compares;
	int            cyc;

	dsp_port #(.LW(`DSP_LANE_W), .DW(DW), .AW(AW), .BUF_N(`DSP_BUF_N)) dut (
		.CORE_CLK(core_clk), .RST(rst), .CLK_EN(clk_en), .K_CLK(k_clk), .K_CLK_N(k_clk_n),
		.OUT_CLK(out_clk), .OUT_CLK_N(out_clk_n), .LOAD_STROBE_N(ld_n), .READ_WRITE(rw),
		.ADDR(addr), .BYTE_LANE_WRITE_N(lanes_n), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OUT_EN_N(dout_en_n), .ECHO_CLOCK_POS(echo_pos), .ECHO_CLOCK_NEG(echo_neg));

	dsp_master #(.DW(DW), .NB(NB), .AW(AW)) mst (
		.tied(tied), .k_clk(k_clk), .k_clk_n(k_clk_n), .out_clk(out_clk),
		.out_clk_n(out_clk_n), .load_strobe_n(ld_n), .read_write(rw), .addr(addr),
		.byte_lane_write_n(lanes_n), .din(din), .q(dout), .q_en_n(dout_en_n),
		.echo_pos(echo_pos), .echo_neg(echo_neg));

	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	// ----------------------------------------
	// closing and hang guard
	// ----------------------------------------
	task automatic end_sim();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	// whole run is about 430 core cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			$display("ERROR %0t: run did not finish", $time);
			end_sim();
		end
	end

	// ----------------------------------------
	// bus operations
	// ----------------------------------------
	task automatic nop();
		mst.tick(1'b1, 1'b1, '0, '1, '0, '1, '0);
	endtask : nop

	// data follows one period later, next command no sooner than that
	task automatic wr(input logic [AW-1:0] a, input logic [NB-1:0] m0,
			input logic [DW-1:0] d0, input logic [NB-1:0] m1, input logic [DW-1:0] d1);
		mst.tick(1'b0, 1'b0, a, '1, '0, '1, '0);
		mst.tick(1'b1, 1'b1, '0, m0, d0, m1, d1);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, e1);
		mst.tick(1'b0, 1'b1, a, '1, '0, '1, '0);
		nop();
		nop();
		`DSP_CHK(mst.q_a, e0)
		`DSP_CHK(mst.q_b, e1)
		`DSP_CHK({mst.en_a, mst.en_b}, 2'b00)
		`DSP_CHK(mst.echo_a, 2'b01)
		`DSP_CHK(mst.echo_b, 2'b10)
	endtask : rd

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		`DSP_CHK(dout_en_n, `DSP_EN_N_RST)
		`DSP_CHK({echo_pos, echo_neg}, {`DSP_ECHO_POS_RST, `DSP_ECHO_NEG_RST})
	endtask : t_reset

	// read straight after a write comes from the write buffer
	task automatic t_wr_rd();
		wr(8'h05, '0, W0, '0, W1);
		rd(8'h05, W0, W1);
		nop();
		nop();
		`DSP_CHK({mst.en_a, mst.en_b}, 2'b11)
	endtask : t_wr_rd

	// one lane per write merges into the same word; second beat aborted
	task automatic t_lanes();
		logic [NB-1:0] m;
		logic [DW-1:0] e;
		e = '0;
		wr(8'h20, '0, '0, '0, P1);
		for (int i = 0; i < NB; i++) begin
			m = '1;
			m[i] = 1'b0;
			e[i*`DSP_LANE_W +: `DSP_LANE_W] = '1;
			wr(8'h20, m, '1, '1, W0);
			rd(8'h20, e, P1);
		end
	endtask : t_lanes

	// lane enables and data around a read must not reach the array
	task automatic t_nowrite();
		mst.tick(1'b0, 1'b1, 8'h20, '1, '0, '1, '0);
		mst.tick(1'b1, 1'b1, '0, '0, W1, '0, W0);
		nop();
		rd(8'h20, '1, P1);
	endtask : t_nowrite

	// output clocks tied high: the input pair times the beats
	task automatic t_tied();
		@(posedge core_clk);
		#2 tied = 1'b1;
		nop();
		nop();
		rd(8'h05, W0, W1);
		@(posedge core_clk);
		#2 tied = 1'b0;
		nop();
	endtask : t_tied

	// burst finished before the clocks stop; outputs must hold
	task automatic t_stop();
		logic [DW-1:0] o;
		logic [2:0]    s;
		rd(8'h20, '1, P1);
		o = dout;
		s = {dout_en_n, echo_pos, echo_neg};
		repeat (16) @(posedge core_clk);
		`DSP_CHK(dout, o)
		`DSP_CHK({dout_en_n, echo_pos, echo_neg}, s)
	endtask : t_stop

	// frozen port must ignore a command and hold its pins
	task automatic t_freeze();
		logic [DW-1:0] o;
		logic [2:0]    s;
		o = dout;
		s = {dout_en_n, echo_pos, echo_neg};
		@(posedge core_clk);
		#2 clk_en = 1'b0;
		mst.tick(1'b0, 1'b1, 8'h05, '1, '0, '1, '0);
		nop();
		nop();
		`DSP_CHK(dout, o)
		`DSP_CHK({dout_en_n, echo_pos, echo_neg}, s)
		@(posedge core_clk);
		#2 clk_en = 1'b1;
		rd(8'h05, W0, W1);
	endtask : t_freeze

	initial begin
		error_cnt = 0;
		compares = 0;
		cyc = 0;
		rst = 1'b1;
		tied = 1'b0;
		clk_en = 1'b1;
		repeat (4) @(posedge core_clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge core_clk);
		// every tick is eight core periods, so this keeps pins off the core edge
		#2;
		t_reset();
		t_wr_rd();
		t_lanes();
		t_nowrite();
		t_tied();
		t_stop();
		t_freeze();
		end_sim();
	end

endmodule : dsp_port_bench
